/* hw/scfg_top.sv */
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "scfg_map.svh"
module scfg_top import scfg_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_match_flag,
   input  wire logic        wait_mode,
   input  wire logic        eng_tx_bit,
   input  wire logic        eng_ss_n,
   output logic             eng_rx_bit,
   output logic             eng_sel_n,
   input  wire logic        ss_i,
   output logic             ss_o,
   output logic             ss_oe,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   output logic             sck_o,
   output logic             sck_oe,
   output logic             spi_clk_run,
   output logic             irq
);
   typedef struct packed {
      logic [7:0]  opt;
      logic [6:0]  rate;
      logic [1:0]  sts;
      logic [1:0]  msk;
      logic [2:0]  mode;
      logic [1:0]  ss_sy;
      logic [1:0]  mosi_sy;
      logic [1:0]  miso_sy;
      logic        match_prev;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        ss_o;
      logic        ss_oe;
      logic        mosi_o;
      logic        mosi_oe;
      logic        miso_o;
      logic        miso_oe;
      logic        rx_bit;
      logic        sel_n;
      logic        sck_oe;
      logic        clk_run;
   } scfg_top_st_t;

   scfg_top_st_t st_q;
   scfg_top_st_t st_d;
   logic         master;
   logic         enabled;
   logic         single;
   logic         bidir_oe;
   logic         halt;
   logic         wr_acc;
   logic         ss_pin;
   logic         mosi_pin;
   logic         miso_pin;
   logic [1:0]   sts_set;
   scfg_ss_fn_t  ss_fn;
   logic         sck_int;

   // Address hit check for the error answer; the read mux decodes the offset itself
   function automatic logic addr_hit(input logic [11:0] a);
      return (a == `SCFG_OFS_OPT) || (a == `SCFG_OFS_RATE) || (a == `SCFG_OFS_STS) ||
             (a == `SCFG_OFS_MASK) || (a == `SCFG_OFS_MODE) || (a == `SCFG_OFS_PINS);
   endfunction

   // Configuration views of the stored registers
   assign master   = st_q.mode[`SCFG_MODE_MASTER];
   assign enabled  = st_q.mode[`SCFG_MODE_EN];
   assign single   = st_q.opt[`SCFG_OPT_SINGLE];
   assign bidir_oe = st_q.opt[`SCFG_OPT_BIDIR_OE];
   assign halt     = wait_mode && st_q.opt[`SCFG_OPT_HALT_WAIT];
   assign ss_fn    = scfg_ss_fn(master, st_q.opt[`SCFG_OPT_FAULT_EN], st_q.mode[`SCFG_MODE_SEL_OE]);
   // Pins are only read after the second synchroniser stage
   assign ss_pin   = st_q.ss_sy[1];
   assign mosi_pin = st_q.mosi_sy[1];
   assign miso_pin = st_q.miso_sy[1];
   // Writes land at the access edge where pready is seen high
   assign wr_acc   = psel && penable && pready && pwrite;

   // Sticky event sources: rising match flag and a low select pin as fault input
   always_comb begin
      sts_set = 2'h0;
      sts_set[`SCFG_STS_MATCH] = rx_match_flag && !st_q.match_prev;
      sts_set[`SCFG_STS_FAULT] = enabled && (ss_fn == SCFG_SS_FAULT_IN) && !ss_pin;
   end

   // Next state of registers, pins and bus answer
   always_comb begin
      st_d = st_q;
      st_d.ss_sy      = {st_q.ss_sy[0], ss_i};
      st_d.mosi_sy    = {st_q.mosi_sy[0], mosi_i};
      st_d.miso_sy    = {st_q.miso_sy[0], miso_i};
      st_d.match_prev = rx_match_flag;

      // Register writes; unmapped offsets are dropped
      if (wr_acc) begin
         unique case (paddr)
            `SCFG_OFS_OPT:  st_d.opt  = pwdata[7:0] & `SCFG_OPT_WMASK;
            `SCFG_OFS_RATE: st_d.rate = pwdata[6:0];
            `SCFG_OFS_MASK: st_d.msk  = pwdata[1:0];
            `SCFG_OFS_MODE: st_d.mode = pwdata[2:0];
            default: ;
         endcase
      end

      // Write one clears, but a same-cycle event still sets
      st_d.sts = st_q.sts;
      if (wr_acc && (paddr == `SCFG_OFS_STS))
         st_d.sts = st_q.sts & ~pwdata[1:0];
      st_d.sts = st_d.sts | sts_set;

      // Answer is prepared in the setup cycle so every bus output is a flop
      st_d.pready  = psel && !penable;
      st_d.pslverr = psel && !penable && !addr_hit(paddr);
      st_d.prdata  = 32'h0000_0000;
      if (psel && !penable) begin
         unique case (paddr)
            `SCFG_OFS_OPT:  st_d.prdata[7:0] = st_q.opt;
            `SCFG_OFS_RATE: st_d.prdata[6:0] = st_q.rate;
            `SCFG_OFS_STS:  st_d.prdata[1:0] = st_q.sts;
            `SCFG_OFS_MASK: st_d.prdata[1:0] = st_q.msk;
            `SCFG_OFS_MODE: st_d.prdata[2:0] = st_q.mode;
            `SCFG_OFS_PINS: st_d.prdata[2:0] = {miso_pin, mosi_pin, ss_pin};
            default: ;
         endcase
      end

      // Match request follows the live flag; other events go through the mask
      st_d.irq = (st_q.opt[`SCFG_OPT_MATCH_IE] && rx_match_flag) ||
                 |(st_q.sts & st_q.msk);

      // Select pin role
      st_d.ss_o  = eng_ss_n;
      st_d.ss_oe = enabled && (ss_fn == SCFG_SS_SEL_OUT);
      unique case (ss_fn)
         SCFG_SS_SEL_IN:   st_d.sel_n = ss_pin;
         SCFG_SS_FAULT_IN: st_d.sel_n = ss_pin;
         default:          st_d.sel_n = 1'b1;
      endcase

      // Data pins; the shared pin is MOSI for a master and MISO for a slave
      st_d.mosi_o  = eng_tx_bit;
      st_d.miso_o  = eng_tx_bit;
      st_d.mosi_oe = 1'b0;
      st_d.miso_oe = 1'b0;
      if (enabled) begin
         if (!single) begin
            // Slave drives only while selected so it never fights another slave
            st_d.mosi_oe = master;
            st_d.miso_oe = !master && !ss_pin;
         end else if (master) begin
            st_d.mosi_oe = bidir_oe;
         end else begin
            st_d.miso_oe = bidir_oe;
         end
      end
      // Receive pin: MOSI when master equals single-wire select, else MISO
      st_d.rx_bit = (master == single) ? mosi_pin : miso_pin;

      st_d.sck_oe  = enabled && master;
      st_d.clk_run = !halt;
   end

   // Single register stage for all state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q      <= '0;
         st_q.opt  <= `SCFG_OPT_RST;
         st_q.rate <= `SCFG_RATE_RST;
         st_q.sts  <= `SCFG_STS_RST;
         st_q.mode <= `SCFG_MODE_RST;
         st_q.sel_n   <= 1'b1;
         st_q.ss_o    <= 1'b1;
         st_q.clk_run <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Reserved divider codes above eight behave as eight; software keeps off them
   scfg_baud u_baud (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (enabled && master),
      .hold    (halt),
      .pre_sel (st_q.rate[`SCFG_RATE_PRE_HI:`SCFG_RATE_PRE_LO]),
      .div_sel (st_q.rate[`SCFG_RATE_DIV_HI:`SCFG_RATE_DIV_LO]),
      .sck     (sck_int)
   );

   assign prdata      = st_q.prdata;
   assign pready      = st_q.pready;
   assign pslverr     = st_q.pslverr;
   assign irq         = st_q.irq;
   assign ss_o        = st_q.ss_o;
   assign ss_oe       = st_q.ss_oe;
   assign mosi_o      = st_q.mosi_o;
   assign mosi_oe     = st_q.mosi_oe;
   assign miso_o      = st_q.miso_o;
   assign miso_oe     = st_q.miso_oe;
   assign eng_rx_bit  = st_q.rx_bit;
   assign eng_sel_n   = st_q.sel_n;
   assign sck_o       = sck_int;
   assign sck_oe      = st_q.sck_oe;
   assign spi_clk_run = st_q.clk_run;

   property p_opt_rsvd;
      @(posedge clk) disable iff (!rst_n)
      (psel && penable && pready && !pwrite && paddr == `SCFG_OFS_OPT) |->
         (prdata[6:5] == 2'h0) && (prdata[2] == 1'b0) && (prdata[31:8] == 24'h0);
   endproperty
   a_opt_rsvd: assert property (p_opt_rsvd) else $error("option reserved bits read nonzero");

   property p_match_irq;
      @(posedge clk) disable iff (!rst_n)
      (st_q.opt[`SCFG_OPT_MATCH_IE] && rx_match_flag) |=> irq;
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match interrupt not raised");

   property p_match_quiet;
      @(posedge clk) disable iff (!rst_n)
      (!st_q.opt[`SCFG_OPT_MATCH_IE] && ((st_q.sts & st_q.msk) == 2'h0)) |=> !irq;
   endproperty
   a_match_quiet: assert property (p_match_quiet) else $error("interrupt raised while gated");

   property p_slave_sel;
      @(posedge clk) disable iff (!rst_n)
      !master |=> (!ss_oe && (eng_sel_n == $past(ss_pin)));
   endproperty
   a_slave_sel: assert property (p_slave_sel) else $error("slave select pin not an input");

   property p_gpio;
      @(posedge clk) disable iff (!rst_n)
      (master && !st_q.opt[`SCFG_OPT_FAULT_EN]) |=> (!ss_oe && eng_sel_n);
   endproperty
   a_gpio: assert property (p_gpio) else $error("select pin used while released to GPIO");

   property p_sel_out;
      @(posedge clk) disable iff (!rst_n)
      (enabled && ss_fn == SCFG_SS_SEL_OUT) |=> (ss_oe && ss_o == $past(eng_ss_n));
   endproperty
   a_sel_out: assert property (p_sel_out) else $error("automatic select output not driven");

   property p_fault_set;
      @(posedge clk) disable iff (!rst_n)
      (enabled && ss_fn == SCFG_SS_FAULT_IN && !ss_pin) |=> st_q.sts[`SCFG_STS_FAULT];
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("mode fault not recorded");

   property p_bidir;
      @(posedge clk) disable iff (!rst_n)
      (enabled && single) |=> ($past(master) ?
         (mosi_oe == $past(bidir_oe) && !miso_oe) : (miso_oe == $past(bidir_oe) && !mosi_oe));
   endproperty
   a_bidir: assert property (p_bidir) else $error("shared data pin direction wrong");

   property p_normal;
      @(posedge clk) disable iff (!rst_n)
      (enabled && !single && master) |=> (mosi_oe && !miso_oe && eng_rx_bit == $past(miso_pin));
   endproperty
   a_normal: assert property (p_normal) else $error("normal master pins wrong");

   property p_halt;
      @(posedge clk) disable iff (!rst_n)
      (wait_mode && st_q.opt[`SCFG_OPT_HALT_WAIT]) |=> !spi_clk_run;
   endproperty
   a_halt: assert property (p_halt) else $error("clocks not stopped in wait");

   property p_rate_rd;
      @(posedge clk) disable iff (!rst_n)
      (psel && penable && pready && !pwrite && paddr == `SCFG_OFS_RATE) |->
         (prdata[31:7] == 25'h0);
   endproperty
   a_rate_rd: assert property (p_rate_rd) else $error("rate bit 7 read nonzero");

   // Clear halt bit or no wait: the clocks must keep running
   property p_clk_run;
      @(posedge clk) disable iff (!rst_n)
      !halt |=> spi_clk_run;
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clocks stopped outside halted wait");

   // Normal slave: listens on MOSI, talks on MISO only while selected
   property p_norm_slave;
      @(posedge clk) disable iff (!rst_n)
      (enabled && !single && !master) |=>
         (!mosi_oe && (miso_oe == !$past(ss_pin)) && (eng_rx_bit == $past(mosi_pin)));
   endproperty
   a_norm_slave: assert property (p_norm_slave) else $error("normal slave pins wrong");

   // Two-wire mode: MOSI direction follows the role alone, drive enable ignored
   property p_two_wire;
      @(posedge clk) disable iff (!rst_n)
      (enabled && !single) |=> (mosi_oe == $past(master));
   endproperty
   a_two_wire: assert property (p_two_wire) else $error("drive enable used in two-wire mode");

   // Single wire: received bit comes from the shared pin of the current role
   property p_shared_rx;
      @(posedge clk) disable iff (!rst_n)
      (enabled && single) |=> (eng_rx_bit == ($past(master) ? $past(mosi_pin) : $past(miso_pin)));
   endproperty
   a_shared_rx: assert property (p_shared_rx) else $error("shared pin receive path wrong");

   // No serial clock leaves the block unless enabled as master
   property p_sck_off;
      @(posedge clk) disable iff (!rst_n)
      !(enabled && master) |=> (!sck_oe && !sck_o);
   endproperty
   a_sck_off: assert property (p_sck_off) else $error("serial clock active while not master");

   // Unimplemented option bits never store a written one
   property p_opt_wr;
      @(posedge clk) disable iff (!rst_n)
      (psel && penable && pready && pwrite && paddr == `SCFG_OFS_OPT) |=>
         ((st_q.opt[6:5] == 2'h0) && !st_q.opt[2]);
   endproperty
   a_opt_wr: assert property (p_opt_wr) else $error("option reserved bits stored a one");
endmodule // scfg_top

/* include/scfg_map.svh */
`ifndef SCFG_MAP_SVH
`define SCFG_MAP_SVH
// Register byte offsets on the APB slave
`define SCFG_OFS_OPT    12'h000
`define SCFG_OFS_RATE   12'h004
`define SCFG_OFS_STS    12'h008
`define SCFG_OFS_MASK   12'h00c
`define SCFG_OFS_MODE   12'h010
`define SCFG_OFS_PINS   12'h014
// Option control fields
`define SCFG_OPT_MATCH_IE  7
`define SCFG_OPT_FAULT_EN  4
`define SCFG_OPT_BIDIR_OE  3
`define SCFG_OPT_HALT_WAIT 1
`define SCFG_OPT_SINGLE    0
`define SCFG_OPT_WMASK     8'h9b
`define SCFG_OPT_RST       8'h00
// Bit rate fields
`define SCFG_RATE_PRE_HI   6
`define SCFG_RATE_PRE_LO   4
`define SCFG_RATE_DIV_HI   3
`define SCFG_RATE_DIV_LO   0
`define SCFG_RATE_RST      7'h00
`define SCFG_RATE_DIV_MAX  4'h8
// Event status and mask fields
`define SCFG_STS_MATCH     0
`define SCFG_STS_FAULT     1
`define SCFG_STS_RST       2'h0
// Mode fields
`define SCFG_MODE_MASTER   0
`define SCFG_MODE_SEL_OE   1
`define SCFG_MODE_EN       2
`define SCFG_MODE_RST      3'h0
`endif

/* include/scfg_pkg.sv */
package scfg_pkg;
   // Function of the slave-select pin
   typedef enum logic [1:0] {
      SCFG_SS_GPIO,
      SCFG_SS_FAULT_IN,
      SCFG_SS_SEL_OUT,
      SCFG_SS_SEL_IN
   } scfg_ss_fn_t;

   // Pin role decode from master, fault enable, select output enable
   function automatic scfg_ss_fn_t scfg_ss_fn(input logic master, input logic fault_en,
                                              input logic sel_oe);
      if (!master)
         return SCFG_SS_SEL_IN;
      else if (!fault_en)
         return SCFG_SS_GPIO;
      else if (sel_oe)
         return SCFG_SS_SEL_OUT;
      else
         return SCFG_SS_FAULT_IN;
   endfunction
endpackage

/* hw/scfg_baud.sv */
`timescale 1ns/1ps
`include "scfg_map.svh"
module scfg_baud import scfg_pkg::*; (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       hold,
   input  wire logic [2:0] pre_sel,
   input  wire logic [3:0] div_sel,
   output logic            sck
);
   typedef struct packed {
      logic [2:0] pcnt;
      logic [8:0] rcnt;
      logic       sck;
   } scfg_baud_st_t;

   scfg_baud_st_t st_q;
   scfg_baud_st_t st_d;
   logic    [3:0] code;
   logic    [8:0] half;

   // Reserved codes clamp to the largest divisor so the counter stays bounded
   assign code = (div_sel > `SCFG_RATE_DIV_MAX) ? `SCFG_RATE_DIV_MAX : div_sel;
   assign half = 9'((10'h1 << code) - 10'h1);

   // Prescaler feeds the rate divider; sck toggles each half period
   always_comb begin
      st_d = st_q;
      if (!run) begin
         st_d = '0;
      end else if (!hold) begin
         if (st_q.pcnt == pre_sel) begin
            st_d.pcnt = 3'h0;
            if (st_q.rcnt == half) begin
               st_d.rcnt = 9'h000;
               st_d.sck  = ~st_q.sck;
            end else begin
               st_d.rcnt = st_q.rcnt + 9'h001;
            end
         end else begin
            st_d.pcnt = st_q.pcnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign sck = st_q.sck;

   property p_sck_cause;
      @(posedge clk) disable iff (!rst_n)
      (run && $past(run) && $changed(st_q.sck)) |->
         ($past(st_q.pcnt) == $past(pre_sel)) && ($past(st_q.rcnt) == $past(half)) && !$past(hold);
   endproperty
   a_sck_cause: assert property (p_sck_cause) else $error("sck toggled off its divider count");

   property p_hold_freeze;
      @(posedge clk) disable iff (!rst_n)
      (run && hold) |=> (run |-> $stable(st_q.sck) && $stable(st_q.pcnt));
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("divider moved while halted");
endmodule // scfg_baud

/* bench/scfg_far.sv */
`timescale 1ns/1ps
// Far SPI device: drives the pins that our device leaves free
module scfg_far (
   input  wire logic       clk,
   input  wire logic       ss_o,
   input  wire logic       ss_oe,
   input  wire logic       mosi_o,
   input  wire logic       mosi_oe,
   input  wire logic       miso_o,
   input  wire logic       miso_oe,
   input  wire logic [2:0] far_v,
   input  wire logic [2:0] far_oe,
   output logic            ss_i,
   output logic            mosi_i,
   output logic            miso_i
);
   logic flt_q;

   // No pull on these lines, so a free line shows a changing level, never a stale one
   initial flt_q = 1'b0;
   always @(posedge clk) flt_q <= ~flt_q;

   // Our device wins, else the far device, else the line floats
   assign ss_i   = ss_oe   ? ss_o   : (far_oe[2] ? far_v[2] : flt_q);
   assign mosi_i = mosi_oe ? mosi_o : (far_oe[1] ? far_v[1] : flt_q);
   assign miso_i = miso_oe ? miso_o : (far_oe[0] ? far_v[0] : flt_q);
endmodule // scfg_far

/* bench/tb_spi_pin_and_baud_config.sv */
`timescale 1ns/1ps
`include "scfg_map.svh"
module tb_spi_pin_and_baud_config;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, eng_rx_bit, eng_sel_n, ss_i, ss_o, ss_oe;
   logic        mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, sck_o, sck_oe, spi_clk_run, irq;
   logic        rx_match_flag = 1'b0;
   logic        wait_mode = 1'b0;
   logic        eng_tx_bit = 1'b0;
   logic        eng_ss_n = 1'b1;
   logic [2:0]  far_v = 3'h7;
   logic [2:0]  far_oe = 3'h0;
   logic        smp = 1'b0;
   logic        per_mode = 1'b0;
   logic [15:0] per_got = 16'h0;
   logic [32:0] exp_q[$];
   logic [31:0] pin_q[$];
   logic [32:0] nr;
   logic [31:0] np;
   int          err_total = 0;
   int          cmp_count = 0;
   int          seed = 38;
   wire  [15:0] pins = {5'h00, ss_oe, ss_o, mosi_oe, mosi_o, miso_oe, miso_o, sck_oe, eng_sel_n,
                        eng_rx_bit, spi_clk_run, irq};

   initial forever #25 clk = ~clk;

   scfg_top dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                   .rx_match_flag, .wait_mode, .eng_tx_bit, .eng_ss_n, .eng_rx_bit, .eng_sel_n, .ss_i, .ss_o,
                   .ss_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .sck_o, .sck_oe,
                   .spi_clk_run, .irq);
   scfg_far far_u (.clk, .ss_o, .ss_oe, .mosi_o, .mosi_oe, .miso_o, .miso_oe, .far_v, .far_oe, .ss_i,
                   .mosi_i, .miso_i);

   task stop_test;
      $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task fail(input logic [32:0] g, input logic [32:0] e);
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
   endtask

   // APB master; holds the request until pready is seen high, then lets go
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         exp_q.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      // Ready is looked at only on rising edges; release happens at that same edge
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail(0, 1);
         stop_test;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask

   // Notes a pin expectation; the monitor samples it mid-cycle
   task pin(input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      pin_q.push_back({m, e});
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
   endtask

   // Times one full serial clock period; the first rises may belong to the old rate
   task per_meas;
      int  n;
      logic prv, cur;
      cur = sck_o;
      repeat (3) begin
         n = 0;
         do begin
            @(negedge clk);
            n++;
            prv = cur;
            cur = sck_o;
         end while (!(cur === 1'b1 && prv === 1'b0) && n < 9000);
         if (n >= 9000) begin
            fail(0, 1);
            stop_test;
         end
      end
      per_got = 16'(n);
   endtask

   // Read answers are matched with the oldest note at the edge that takes them
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         nr = exp_q.pop_front();
         cmp_count++;
         if ({pslverr, prdata} !== nr)
            fail({pslverr, prdata}, nr);
      end
   end

   // Pin and period results
   always @(negedge clk) begin
      if (smp) begin
         np = pin_q.pop_front();
         cmp_count++;
         if (((per_mode ? per_got : pins) & np[31:16]) !== (np[15:0] & np[31:16]))
            fail({17'h0, per_mode ? per_got : pins}, {17'h0, np[15:0]});
      end
   end

   initial begin
      logic       mst, soe, fen, sgl, bdo, tx, sn, ess, emo, emi;
      logic [2:0] fv;
      int         dv, pv;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(`SCFG_OFS_OPT, 32'h0);
      rd(`SCFG_OFS_RATE, 32'h0);
      wr(`SCFG_OFS_OPT, 32'hff);
      rd(`SCFG_OFS_OPT, 32'h9b);
      wr(`SCFG_OFS_RATE, 32'hff);
      rd(`SCFG_OFS_RATE, 32'h7f);
      apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
      // Every combination of role, select mode and pin mode
      for (int i = 0; i < 32; i++) begin
         {mst, soe, fen, sgl, bdo} = 5'(i);
         fv = 3'($random(seed));
         tx = 1'($random(seed));
         sn = 1'($random(seed));
         ess = mst & fen & soe;
         emo = mst & (!sgl | bdo);
         emi = !mst & (sgl ? bdo : !fv[2]);
         eng_tx_bit <= tx;
         eng_ss_n <= sn;
         far_v <= fv;
         far_oe <= {!ess, !emo, !emi};
         wr(`SCFG_OFS_MODE, {29'h0, 1'b1, soe, mst});
         wr(`SCFG_OFS_OPT, {27'h0, fen, bdo, 2'b00, sgl});
         repeat (4) @(posedge clk);
         pin({5'h00, 1'b1, ess, 1'b1, emo, 1'b1, emi, 1'b1, 1'b1, !(sgl & bdo), 2'b11},
             {5'h00, ess, sn, emo, tx, emi, tx, mst, (mst & (!fen | soe)) | fv[2],
              mst ? (sgl ? fv[1] : fv[0]) : (sgl ? fv[0] : fv[1]), 2'b10});
      end
      // Serial clock period over every legal divider code
      wr(`SCFG_OFS_MODE, 32'h5);
      wr(`SCFG_OFS_OPT, 32'h0);
      for (dv = 0; dv <= 8; dv++) begin // Codes above eight are not written in this loop
         pv = $random(seed) & 7;
         wr(`SCFG_OFS_RATE, {25'h0, 3'(pv), 4'(dv)});
         per_meas;
         per_mode = 1'b1;
         pin(16'hffff, 16'((pv + 1) << (dv + 1)));
         per_mode = 1'b0;
      end
      // Wait mode with and without the halt bit
      wr(`SCFG_OFS_OPT, 32'h2);
      @(posedge clk);
      wait_mode <= 1'b1;
      repeat (3) @(posedge clk);
      pin(16'h0002, 16'h0000);
      wr(`SCFG_OFS_OPT, 32'h0);
      repeat (2) @(posedge clk);
      pin(16'h0002, 16'h0002);
      wait_mode <= 1'b0;
      // Match interrupt: live enable, sticky status, mask, write-one clear
      wr(`SCFG_OFS_STS, 32'h3);
      wr(`SCFG_OFS_MASK, 32'h0);
      wr(`SCFG_OFS_OPT, 32'h80);
      @(posedge clk);
      rx_match_flag <= 1'b1;
      repeat (3) @(posedge clk);
      pin(16'h0001, 16'h0001);
      wr(`SCFG_OFS_OPT, 32'h0);
      repeat (2) @(posedge clk);
      pin(16'h0001, 16'h0000);
      rd(`SCFG_OFS_STS, 32'h1);
      wr(`SCFG_OFS_MASK, 32'h1);
      repeat (2) @(posedge clk);
      pin(16'h0001, 16'h0001);
      wr(`SCFG_OFS_STS, 32'h1);
      repeat (2) @(posedge clk);
      pin(16'h0001, 16'h0000);
      rd(`SCFG_OFS_STS, 32'h0);
      stop_test;
   end
endmodule // tb_spi_pin_and_baud_config
